// ---- rtl/vicr_regs.vh ----
// Command codes, field positions and reset values of the video config bank
`ifndef VICR_REGS_VH
`define VICR_REGS_VH
`define VICR_CMD_POL        8'hd2
`define VICR_CMD_VBACK      8'hd3
`define VICR_CMD_VFRONT     8'hd4
`define VICR_CMD_HBACK      8'hd5
`define VICR_CMD_HFRONT     8'hd6
`define VICR_CMD_MAKER      8'hda
`define VICR_CMD_VERSION    8'hdb
`define VICR_CMD_DRIVER     8'hdc
`define VICR_CMD_PORTSEL    8'hf3
`define VICR_CMD_VENDOR     8'hf4
`define VICR_CMD_TEST       8'hf5
`define VICR_CMD_CLKHI      8'hf6
`define VICR_CMD_CLKLO      8'hf7
`define VICR_POL_RST        8'h03
`define VICR_VBACK_RST      6'h02
`define VICR_PORCH_RST      6'h04
`define VICR_PORTSEL_RST    8'h80
`define VICR_TEST_POR       8'h00
`define VICR_CLKHI_RST      8'h50
`define VICR_CLKLO_RST      8'h78
`define VICR_POL_MASK       8'h4f
`define VICR_PORCH_MASK     8'h3f
`define VICR_PORTSEL_MASK   8'h8d
`define VICR_CLKHI_MASK     8'hf1
`define VICR_BIT_VSYNC      0
`define VICR_BIT_HSYNC      1
`define VICR_BIT_DEPOL      2
`define VICR_BIT_PCLK       3
`define VICR_BIT_MODE       6
`define VICR_BIT_MAIN       7
`define VICR_BIT_EXTRA      0
`define VICR_BIT_TEST_HI    7
`define VICR_BIT_EXTCLK     0
`define VICR_SEC_LSB        2
`define VICR_PINS_110       3'h6
`define VICR_PINS_000       3'h0
`define VICR_PINS_010       3'h2
`define VICR_PINS_011       3'h3
`define VICR_SEC_I2C        2'h0
`define VICR_SEC_SPI9       2'h1
`define VICR_SEC_SPI8       2'h2
`define VICR_VER_MSB        8'h80
`endif

// ---- rtl/vicr_video_cfg.v ----
// Video interface configuration and identification register bank
// Functional notes
// [R1] Pixel clock polarity bit: 0 samples rising edge, 1 falling edge.
// [R2] Data enable polarity bit: 0 high active, 1 low active.
// [R3] Sync polarity bits: 0 active high, 1 active low.
// [R4] Bit 6 of polarity register selects RGB mode; reset gives mode 1.
// [R5] Vertical porches are used in MIPI video mode and RGB mode 2.
// [R6] Horizontal porches are used only in RGB mode 2.
// [R7] Vertical porch fields are six bits, counted in lines.
// [R8] Horizontal porch fields are six bits, counted in pixel clocks.
// [R9] Host keeps vertical back porch in 2..63, other porches 4..63.
// [R10] All resets load polarity 03h, VERT_BACK_PORCH_LINES 2, other porches 4.
// [R11] Main port bit picks MIPI or secondary port for modes 000/010/011.
// [R12] Extra port enable acts only when mode pins are 110b.
// [R13] Secondary field: 00 I2C, 01 SPI9, 10 SPI8, 11 none.
// [R14] Host never accesses registers through two ports at once.
// [R15] Read-only maker identification byte.
// [R16] Read-only version byte with top bit always one.
// [R17] Read-only hard-wired vendor identification byte.
// [R18] Test byte: power-on clears all, other resets clear bit 7 only.
// [R19] Clock source bit: 0 internal oscillator, 1 external clock.
// [R20] Host writes frequency field as 100 times MHz, 9 to 40 MHz.
// [R21] Host rounds frequency to hundredths of a MHz.
// [R22] Clock registers are accessible only in sleep-in state.
// [R23] Sleep exit reloads lane, strobe and 3D registers unless suppressed.
// [R24] Fixed zero bits read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
`include "vicr_regs.vh"
module vicr_video_cfg #(
    parameter [7:0] MAKER_ID   = 8'h5a,  // Arbitrary value
    parameter [6:0] VERSION_LO = 7'h11,  // Arbitrary value
    parameter [7:0] DRIVER_ID  = 8'h3c,  // Arbitrary value
    parameter [7:0] VENDOR_ID  = 8'ha5   // Arbitrary value
) (
    // Clock and resets
    input  wire       clk,
    input  wire       rst,
    input  wire       por,
    input  wire       sw_rst,
    // Command parameter access
    input  wire [7:0] cmd,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    input  wire       rd_en,
    output reg  [7:0] rd_data,
    output reg        rd_valid,
    // Device state
    input  wire       sleep_in,
    input  wire       sleep_exit,
    input  wire       reload_suppress,
    input  wire [2:0] interface_mode_pins,
    input  wire       mipi_video_mode,
    // Video interface controls
    output wire       pixel_clock_edge_sel,
    output wire       data_enable_polarity,
    output wire       hsync_active_low,
    output wire       vsync_active_low,
    output wire       rgb_mode2,
    output wire       de_active_level,
    output wire [5:0] vert_back_porch_lines,
    output wire [5:0] vert_front_porch_lines,
    output wire [5:0] horiz_back_porch_clocks,
    output wire [5:0] horiz_front_porch_clocks,
    output wire       vert_porch_used,
    output wire       horiz_porch_used,
    // Host port routing
    output wire       mipi_access_en,
    output wire       i2c_access_en,
    output wire       spi9_access_en,
    output wire       spi8_access_en,
    // Display clock
    output wire       external_clock_select,
    output wire [11:0] external_freq_hundredths,
    // Sleep exit reload request
    output reg        reload_pulse
);

// ****************************************************************
// Register storage
// ****************************************************************
reg [7:0] pol_r;
reg [5:0] vback_r;
reg [5:0] vfront_r;
reg [5:0] hback_r;
reg [5:0] hfront_r;
reg [7:0] portsel_r;
reg [7:0] test_r;
reg [7:0] clkhi_r;
reg [7:0] clklo_r;

// ****************************************************************
// Reset and access qualifiers
// ****************************************************************
wire any_rst = rst | por | sw_rst;
wire clk_ok  = sleep_in;                                    // [R22]

function wr_hit;
    input [7:0] c;
    input [7:0] a;
    input       e;
    begin
        wr_hit = e && (c == a);
    end
endfunction

// ****************************************************************
// Write path
// ****************************************************************
wire wr_pol    = wr_hit(cmd, `VICR_CMD_POL, wr_en);
wire wr_vback  = wr_hit(cmd, `VICR_CMD_VBACK, wr_en);
wire wr_vfront = wr_hit(cmd, `VICR_CMD_VFRONT, wr_en);
wire wr_hback  = wr_hit(cmd, `VICR_CMD_HBACK, wr_en);
wire wr_hfront = wr_hit(cmd, `VICR_CMD_HFRONT, wr_en);
// Clock registers take writes only in sleep-in
wire wr_clkhi  = wr_hit(cmd, `VICR_CMD_CLKHI, wr_en && clk_ok);     // [R22]
wire wr_clklo  = wr_hit(cmd, `VICR_CMD_CLKLO, wr_en && clk_ok);     // [R22]

// Signal polarity and RGB mode
always @(posedge clk) begin
    if (any_rst) begin
        pol_r <= `VICR_POL_RST;                             // [R10]
    end else if (wr_pol) begin
        pol_r <= wr_data & `VICR_POL_MASK;                  // [R24]
    end
end

// Porch counts
always @(posedge clk) begin
    if (any_rst) begin
        vback_r <= `VICR_VBACK_RST;                         // [R10]
    end else if (wr_vback) begin
        vback_r <= wr_data[5:0];                            // [R7]
    end
end

always @(posedge clk) begin
    if (any_rst) begin
        vfront_r <= `VICR_PORCH_RST;                        // [R10]
    end else if (wr_vfront) begin
        vfront_r <= wr_data[5:0];                           // [R7]
    end
end

always @(posedge clk) begin
    if (any_rst) begin
        hback_r <= `VICR_PORCH_RST;                         // [R10]
    end else if (wr_hback) begin
        hback_r <= wr_data[5:0];                            // [R8]
    end
end

always @(posedge clk) begin
    if (any_rst) begin
        hfront_r <= `VICR_PORCH_RST;                        // [R10]
    end else if (wr_hfront) begin
        hfront_r <= wr_data[5:0];                           // [R8]
    end
end

// Display clock control
always @(posedge clk) begin
    if (any_rst) begin
        clkhi_r <= `VICR_CLKHI_RST;
    end else if (wr_clkhi) begin
        clkhi_r <= wr_data & `VICR_CLKHI_MASK;              // [R24]
    end
end

always @(posedge clk) begin
    if (any_rst) begin
        clklo_r <= `VICR_CLKLO_RST;
    end else if (wr_clklo) begin
        clklo_r <= wr_data;                                 // [R20]
    end
end

// ****************************************************************
// Port select and test byte
// ****************************************************************
// Port select keeps its value over software reset
always @(posedge clk) begin
    if (rst || por) begin
        portsel_r <= `VICR_PORTSEL_RST;
    end else if (wr_hit(cmd, `VICR_CMD_PORTSEL, wr_en)) begin
        portsel_r <= wr_data & `VICR_PORTSEL_MASK;          // [R24]
    end
end

// Test byte: low bits survive hardware and software reset
always @(posedge clk) begin
    if (por) begin
        test_r <= `VICR_TEST_POR;                           // [R18]
    end else if (rst || sw_rst) begin
        test_r[`VICR_BIT_TEST_HI] <= 1'b0;                  // [R18]
    end else if (wr_hit(cmd, `VICR_CMD_TEST, wr_en)) begin
        test_r <= wr_data;
    end
end

// ****************************************************************
// Read path
// ****************************************************************
// Porch fields read back with the fixed-zero top bits
function [7:0] porch_byte;
    input [5:0] f;
    begin
        porch_byte = {2'h0, f};                             // [R24]
    end
endfunction

reg [7:0] rd_nxt;
always @* begin
    rd_nxt = 8'h00;
    case (cmd)
        `VICR_CMD_POL:     rd_nxt = pol_r;
        `VICR_CMD_VBACK:   rd_nxt = porch_byte(vback_r);
        `VICR_CMD_VFRONT:  rd_nxt = porch_byte(vfront_r);
        `VICR_CMD_HBACK:   rd_nxt = porch_byte(hback_r);
        `VICR_CMD_HFRONT:  rd_nxt = porch_byte(hfront_r);
        `VICR_CMD_MAKER:   rd_nxt = MAKER_ID;               // [R15]
        `VICR_CMD_VERSION: rd_nxt = {1'b1, VERSION_LO};     // [R16]
        `VICR_CMD_DRIVER:  rd_nxt = DRIVER_ID;
        `VICR_CMD_PORTSEL: rd_nxt = portsel_r;
        `VICR_CMD_VENDOR:  rd_nxt = VENDOR_ID;              // [R17]
        `VICR_CMD_TEST:    rd_nxt = test_r;
        `VICR_CMD_CLKHI:   rd_nxt = clk_ok ? clkhi_r : 8'h00; // [R22]
        `VICR_CMD_CLKLO:   rd_nxt = clk_ok ? clklo_r : 8'h00; // [R22]
        default:           rd_nxt = 8'h00;
    endcase
end

// ****************************************************************
// Read reply registers
// ****************************************************************
always @(posedge clk) begin
    if (any_rst) begin
        rd_valid <= 1'b0;
    end else begin
        rd_valid <= rd_en;
    end
end

always @(posedge clk) begin
    if (any_rst) begin
        rd_data <= 8'h00;
    end else if (rd_en) begin
        rd_data <= rd_nxt;
    end
end

// ****************************************************************
// Sleep exit reload request
// ****************************************************************
always @(posedge clk) begin
    if (any_rst)
        reload_pulse <= 1'b0;
    else
        reload_pulse <= sleep_exit & ~reload_suppress;      // [R23]
end

// ****************************************************************
// Decoded controls
// ****************************************************************
assign pixel_clock_edge_sel = pol_r[`VICR_BIT_PCLK];        // [R1]
assign data_enable_polarity = pol_r[`VICR_BIT_DEPOL];       // [R2]
assign de_active_level      = ~pol_r[`VICR_BIT_DEPOL];      // [R2]
assign hsync_active_low     = pol_r[`VICR_BIT_HSYNC];       // [R3]
assign vsync_active_low     = pol_r[`VICR_BIT_VSYNC];       // [R3]
assign rgb_mode2            = pol_r[`VICR_BIT_MODE];        // [R4]

// ****************************************************************
// Porch counts
// ****************************************************************
assign vert_back_porch_lines    = vback_r;
assign vert_front_porch_lines   = vfront_r;
assign horiz_back_porch_clocks  = hback_r;
assign horiz_front_porch_clocks = hfront_r;

// ****************************************************************
// Porch usage
// ****************************************************************
assign vert_porch_used  = mipi_video_mode | rgb_mode2;      // [R5]
assign horiz_porch_used = rgb_mode2 & ~mipi_video_mode;     // [R6]

// ****************************************************************
// Interface mode pin decode
// ****************************************************************
reg pins_main;
reg pins_multi;
always @* begin
    pins_main  = 1'b0;
    pins_multi = 1'b0;
    case (interface_mode_pins)
        `VICR_PINS_000: pins_main  = 1'b1;                  // [R11]
        `VICR_PINS_010: pins_main  = 1'b1;                  // [R11]
        `VICR_PINS_011: pins_main  = 1'b1;                  // [R11]
        `VICR_PINS_110: pins_multi = 1'b1;                  // [R12]
        default: begin
            pins_main  = 1'b0;
            pins_multi = 1'b0;
        end
    endcase
end

// ****************************************************************
// Host port routing
// ****************************************************************
wire       main_sec = pins_main & portsel_r[`VICR_BIT_MAIN];    // [R11]
wire       extra_on = pins_multi & portsel_r[`VICR_BIT_EXTRA];  // [R12]
wire [1:0] sec_sel  = portsel_r[`VICR_SEC_LSB+1:`VICR_SEC_LSB];
reg        sec_i2c;
reg        sec_spi9;
reg        sec_spi8;
// Secondary port decode; the last code selects no port
always @* begin
    sec_i2c  = 1'b0;
    sec_spi9 = 1'b0;
    sec_spi8 = 1'b0;
    case (sec_sel)
        `VICR_SEC_I2C:  sec_i2c  = 1'b1;                    // [R13]
        `VICR_SEC_SPI9: sec_spi9 = 1'b1;                    // [R13]
        `VICR_SEC_SPI8: sec_spi8 = 1'b1;                    // [R13]
        default: begin
            sec_i2c  = 1'b0;
            sec_spi9 = 1'b0;
            sec_spi8 = 1'b0;
        end
    endcase
end

assign mipi_access_en = ~main_sec;                          // [R11]
assign i2c_access_en  = main_sec | (extra_on & sec_i2c);    // [R13]
assign spi9_access_en = extra_on & sec_spi9;                // [R13]
assign spi8_access_en = extra_on & sec_spi8;                // [R13]

// ****************************************************************
// Display clock
// ****************************************************************
assign external_clock_select    = clkhi_r[`VICR_BIT_EXTCLK]; // [R19]
assign external_freq_hundredths = {clkhi_r[7:4], clklo_r};   // [R20]

endmodule
`default_nettype wire

// ---- tb/test_video_interface_config_regs.sv ----
// Self-checking bench for the video config register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_video_interface_config_regs;
    logic        clk, rst, por, sw_rst, sleep_in, sleep_exit, sup, mipi, ok;
    logic        wr_en, rd_en, rd_valid, pk, dn, hs, vs, m2, dl, vu, hu;
    logic        ma, ia, s9, s8, ext, rp;
    logic [7:0]  cmd, wr_data, rd_data, d;
    logic [5:0]  vbk, vfr, hbk, hfr;
    logic [11:0] fq;
    logic [2:0]  pins;
    int          n_mismatch = 0, total_checks = 0;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    vicr_video_cfg vicr_video_cfg_inst (.clk(clk), .rst(rst), .por(por),
        .sw_rst(sw_rst), .cmd(cmd), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
        .sleep_in(sleep_in), .sleep_exit(sleep_exit),
        .reload_suppress(sup), .interface_mode_pins(pins),
        .mipi_video_mode(mipi), .pixel_clock_edge_sel(pk),
        .data_enable_polarity(dn), .hsync_active_low(hs),
        .vsync_active_low(vs), .rgb_mode2(m2), .de_active_level(dl),
        .vert_back_porch_lines(vbk), .vert_front_porch_lines(vfr),
        .horiz_back_porch_clocks(hbk), .horiz_front_porch_clocks(hfr),
        .vert_porch_used(vu), .horiz_porch_used(hu), .mipi_access_en(ma),
        .i2c_access_en(ia), .spi9_access_en(s9), .spi8_access_en(s8),
        .external_clock_select(ext), .external_freq_hundredths(fq),
        .reload_pulse(rp));
    vicr_host_model vicr_host_model_inst (.clk(clk), .rd_data(rd_data),
        .rd_valid(rd_valid), .cmd(cmd), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en));
    task test_done;
        begin
            if (n_mismatch == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task wr(input logic [7:0] c, input logic [7:0] v);
        vicr_host_model_inst.wr(c, v);
    endtask
    task rc(input logic [7:0] c, input logic [7:0] e);
        begin
            vicr_host_model_inst.rd(c, d, ok);
            `CHK("rd_valid", 1'b1, ok)
            `CHK("rd_data", e, d)
        end
    endtask
    // Pulse one reset: 0 hardware, 1 power-on, 2 software
    task pulse(input int k);
        begin
            @(posedge clk) {rst, por, sw_rst} <= 3'b100 >> k;
            @(posedge clk) {rst, por, sw_rst} <= 3'b000;
        end
    endtask
    task t_defaults;
        logic [7:0] ca [9] = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hf3,
                               8'hf5, 8'hf6, 8'hf7};
        logic [7:0] ea [9] = '{8'h03, 8'h02, 8'h04, 8'h04, 8'h04, 8'h80,
                               8'h00, 8'h50, 8'h78};
        begin
            foreach (ca[i]) rc(ca[i], ea[i]);
            `CHK("sync_rgb", 3'b110, {hs, vs, m2})
        end
    endtask
    task t_pol_porch;
        begin
            wr(8'hd2, 8'hff);
            rc(8'hd2, 8'h4f);
            `CHK("pol", 7'h7d, {pk, dn, hs, vs, m2, dl, hu})
            @(posedge clk) mipi <= 1'b1;
            wr(8'hd2, 8'h00);
            `CHK("pol_off", 8'h06, {pk, dn, hs, vs, m2, dl, vu, hu})
            for (logic [7:0] c = 8'hd3; c < 8'hd7; c++) wr(c, 8'hff);
            for (logic [7:0] c = 8'hd3; c < 8'hd7; c++) rc(c, 8'h3f);
            `CHK("porch", 24'hffffff, {vbk, vfr, hbk, hfr})
        end
    endtask
    task t_ids;
        logic [7:0] ca [4] = '{8'hda, 8'hdb, 8'hdc, 8'hf4};
        logic [7:0] ea [4] = '{8'h5a, 8'h91, 8'h3c, 8'ha5};
        begin
            foreach (ca[i]) wr(ca[i], ~ea[i]);
            foreach (ca[i]) rc(ca[i], ea[i]);
            wr(8'h01, 8'hff);
            rc(8'h01, 8'h00);
        end
    endtask
    task t_ports;
        begin
            wr(8'hf3, 8'h80);
            `CHK("main_sec", 2'b01, {ma, ia})
            wr(8'hf3, 8'h00);
            `CHK("main_mipi", 2'b10, {ma, ia})
            @(posedge clk) pins <= 3'h6;
            wr(8'hf3, 8'h08);
            `CHK("extra_off", 4'h8, {ma, ia, s9, s8})
            for (int k = 0; k < 4; k++) begin
                wr(8'hf3, {4'h0, k[1:0], 2'b01});
                `CHK("sec", 4'h8 | 4'h4 >> k, {ma, ia, s9, s8})
            end
        end
    endtask
    task t_clock;
        begin
            wr(8'hf6, 8'h51);
            wr(8'hf7, 8'h86);
            `CHK("ext_freq", 13'h1586, {ext, fq})
            wr(8'hf6, 8'hfe);
            rc(8'hf6, 8'hf0);
            @(posedge clk) sleep_in <= 1'b0;
            wr(8'hf7, 8'h00);
            rc(8'hf7, 8'h00);
            `CHK("freq_kept", 13'h0f86, {ext, fq})
        end
    endtask
    task t_resets;
        begin
            wr(8'hf5, 8'hff);
            pulse(2);
            rc(8'hf5, 8'h7f);
            rc(8'hd3, 8'h02);
            pulse(0);
            rc(8'hf5, 8'h7f);
            pulse(1);
            rc(8'hf5, 8'h00);
            @(posedge clk) sleep_exit <= 1'b1;
            @(posedge clk) {sup, sleep_exit} <= 2'b11;
            #1 `CHK("reload", 1'b1, rp)
            @(posedge clk) sleep_exit <= 1'b0;
            #1 `CHK("reload_sup", 1'b0, rp)
        end
    endtask
    initial begin
        {rst, por, sw_rst, sleep_in, sleep_exit, sup, mipi} = 7'b1101000;
        pins = 3'h0;
        repeat (12) @(posedge clk);
        {rst, por} <= 2'b00;
        t_defaults;
        t_pol_porch;
        t_ids;
        t_ports;
        t_clock;
        t_resets;
        test_done;
    end
endmodule
`default_nettype wire

// ---- tb/vicr_host_model.sv ----
// Host model issuing command parameter writes and reads
`timescale 1ns/1ns
`default_nettype none
module vicr_host_model (
    // Clock and reply
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    // Requests from the single host port, never overlapping
    output var  logic [7:0] cmd = 8'h00,
    output var  logic       wr_en = 1'b0,
    output var  logic [7:0] wr_data = 8'h00,
    output var  logic       rd_en = 1'b0
);
    // Callers pass only legal porch and frequency codes
    task wr(input logic [7:0] c, input logic [7:0] v);
        begin
            @(posedge clk);
            cmd <= c;
            wr_en <= 1'b1;
            wr_data <= v;
            @(posedge clk);
            wr_en <= 1'b0;
            wr_data <= ~v;
            #1;
        end
    endtask
    task rd(input logic [7:0] c, output logic [7:0] v, output logic ok);
        begin
            @(posedge clk);
            cmd <= c;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            #1;
            ok = rd_valid;
            v = rd_data;
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/vicr_video_cfg_props.sv ----
// Concurrent checks on the video config register bank ports
`timescale 1ns/1ns
`default_nettype none
`include "vicr_regs.vh"
module vicr_video_cfg_chk (
    // Clock, resets and access
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       por,
    input wire logic       sw_rst,
    input wire logic [7:0] cmd,
    input wire logic       wr_en,
    input wire logic [7:0] wr_data,
    input wire logic       rd_en,
    input wire logic [7:0] rd_data,
    // State and controls
    input wire logic       sleep_in,
    input wire logic       sleep_exit,
    input wire logic       reload_suppress,
    input wire logic       mipi_video_mode,
    input wire logic       rgb_mode2,
    input wire logic       pixel_clock_edge_sel,
    input wire logic [5:0] vert_back_porch_lines,
    input wire logic       vert_porch_used,
    input wire logic       horiz_porch_used,
    input wire logic       reload_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire q = !por && !sw_rst;
    property p_pce;
        wr_en && q && cmd == `VICR_CMD_POL
            |=> pixel_clock_edge_sel == $past(wr_data[3]);
    endproperty
    a_pce: assert property (p_pce) else $error("edge select");
    property p_vu;
        vert_porch_used == (mipi_video_mode || rgb_mode2);
    endproperty
    a_vu: assert property (p_vu) else $error("vert porch use");
    property p_hu;
        horiz_porch_used == (rgb_mode2 && !mipi_video_mode);
    endproperty
    a_hu: assert property (p_hu) else $error("horiz porch use");
    property p_por;
        por |=> vert_back_porch_lines == 6'h02;
    endproperty
    a_por: assert property (p_por) else $error("porch reset");
    property p_ver;
        rd_en && q && cmd == `VICR_CMD_VERSION |=> rd_data[7];
    endproperty
    a_ver: assert property (p_ver) else $error("version msb");
    property p_slp;
        rd_en && q && !sleep_in && cmd == `VICR_CMD_CLKLO
            |=> rd_data == 8'h00;
    endproperty
    a_slp: assert property (p_slp) else $error("clock read");
    property p_zero;
        rd_en && q && cmd == `VICR_CMD_POL |=> rd_data[7] == 1'b0
            && rd_data[5:4] == 2'b00;
    endproperty
    a_zero: assert property (p_zero) else $error("fixed zero");
    property p_rel;
        sleep_exit && !reload_suppress && q |=> reload_pulse;
    endproperty
    a_rel: assert property (p_rel) else $error("reload");
endmodule
bind vicr_video_cfg vicr_video_cfg_chk vicr_video_cfg_chk_inst (
    .clk(clk), .rst(rst), .por(por), .sw_rst(sw_rst), .cmd(cmd),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
    .sleep_in(sleep_in), .sleep_exit(sleep_exit),
    .reload_suppress(reload_suppress), .mipi_video_mode(mipi_video_mode),
    .rgb_mode2(rgb_mode2), .pixel_clock_edge_sel(pixel_clock_edge_sel),
    .vert_back_porch_lines(vert_back_porch_lines),
    .vert_porch_used(vert_porch_used), .horiz_porch_used(horiz_porch_used),
    .reload_pulse(reload_pulse));
`default_nettype wire
